/* src/adm_pkg.sv */
// package with register map, field layout and constants of the measurement/coefficient block
package adm_pkg;
    // page numbers
    localparam logic [7:0] PAGE_0            = 8'h00;
    localparam logic [7:0] PAGE_1            = 8'h01;
    localparam logic [7:0] PAGE_8            = 8'h08;
    // register addresses inside a page
    localparam logic [7:0] REG_PAGE_SEL      = 8'h00;
    localparam logic [7:0] REG_SW_RESET      = 8'h01;
    localparam logic [7:0] REG_ADC_POWER     = 8'h51;
    localparam logic [7:0] REG_DCM_LEN       = 8'h64;
    localparam logic [7:0] REG_DCM_CTRL      = 8'h66;
    localparam logic [7:0] REG_DCM_LATCH     = 8'h67;
    localparam logic [7:0] REG_DCM_LEFT0     = 8'h68;
    localparam logic [7:0] REG_DCM_RIGHT0    = 8'h6B;
    localparam logic [7:0] REG_ANTI_THUMP    = 8'h3A;
    localparam logic [7:0] REG_FAST_CHARGE   = 8'h47;
    localparam logic [7:0] REG_INPUT_ROUTE   = 8'h34;
    localparam logic [7:0] REG_COEF_CTRL     = 8'h01;
    localparam logic [7:0] REG_COEF_BASE     = 8'h08;
    // field positions
    localparam int DCM_EN_HI      = 7;
    localparam int DCM_EN_LO      = 6;
    localparam int DCM_MODE_BIT   = 5;
    localparam int DCM_LEN_HI     = 4;
    localparam int PRST_EN_BIT    = 5;
    localparam int LATCH_HI       = 7;
    localparam int LATCH_LO       = 6;
    localparam int AT_HI          = 7;
    localparam int AT_LO          = 2;
    localparam int FC_HI          = 5;
    localparam int ADC_PWR_L_BIT  = 7;
    localparam int ADC_PWR_R_BIT  = 6;
    localparam int SWAP_BIT       = 0;
    localparam int INUSE_BIT      = 1;
    localparam int ADAPT_BIT      = 2;
    // reset and limits
    localparam logic [7:0] RST_ZERO  = 8'h00;
    localparam logic [4:0] LEN_MIN   = 5'h01;
    localparam logic [4:0] LEN_MAX   = 5'h14;
    localparam int         N_INPUTS  = 6;
    localparam int         N_COEF    = 16;
    localparam int         DATA_W    = 24;
endpackage

/* src/adm_filter.sv */
`timescale 1ns/1ps
// dc measurement filter: averaging or first-order iir, with periodic reset
module adm_filter #(
    parameter int DW = 24
) (
    input  wire logic          clk,
    input  wire logic          rst_n,
    input  wire logic          enable,
    input  wire logic          mod_tick,
    input  wire logic          iir_mode,
    input  wire logic [4:0]    len,
    input  wire logic          prst_en,
    input  wire logic [4:0]    prst_exp,
    input  wire logic [DW-1:0] sample,
    output logic      [DW-1:0] result,
    output logic               prst_pulse
);
    logic [DW+20:0] acc_ff;
    logic [20:0]    cnt_ff;
    logic [31:0]    rst_cnt_ff;
    logic [DW-1:0]  result_ff;
    logic [4:0]     eff_len;
    logic signed [DW+20:0] ext_s;
    logic signed [DW+20:0] iir_step;

    // clamp length into the legal 1..20 range
    assign eff_len = (len < adm_pkg::LEN_MIN) ? adm_pkg::LEN_MIN :
                     (len > adm_pkg::LEN_MAX) ? adm_pkg::LEN_MAX : len;

    // signed error so a falling input shifts arithmetically, not logically
    assign ext_s    = (DW+21)'($signed(sample));
    assign iir_step = (ext_s - $signed(acc_ff)) >>> eff_len;

    // periodic reset every 2^R modulator ticks in averaging mode only; never when disabled
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_cnt_ff <= '0;
        end else if (!enable || !prst_en) begin
            rst_cnt_ff <= '0;
        end else if (mod_tick) begin
            if (rst_cnt_ff >= (32'h1 << prst_exp) - 32'h1) begin
                rst_cnt_ff <= '0;
            end else begin
                rst_cnt_ff <= rst_cnt_ff + 32'h1;
            end
        end
    end
    assign prst_pulse = enable && prst_en && !iir_mode && mod_tick
                        && (rst_cnt_ff >= (32'h1 << prst_exp) - 32'h1);

    // filter state: iir y += (x-y)>>D, averaging sums 2^D samples
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            acc_ff    <= '0;
            cnt_ff    <= '0;
            result_ff <= '0;
        end else if (!enable) begin
            acc_ff <= '0;
            cnt_ff <= '0;
        end else if (mod_tick) begin
            if (iir_mode) begin
                // narrower bandwidth with larger D
                acc_ff    <= acc_ff + iir_step;
                result_ff <= acc_ff[DW-1:0];
            end else if (prst_pulse) begin
                acc_ff <= '0;
                cnt_ff <= '0;
            end else if (cnt_ff == (21'h1 << eff_len) - 21'h1) begin
                result_ff <= DW'((acc_ff + (DW+21)'($signed(sample))) >>> eff_len);
                acc_ff    <= '0;
                cnt_ff    <= '0;
            end else begin
                acc_ff <= acc_ff + (DW+21)'($signed(sample));
                cnt_ff <= cnt_ff + 21'h1;
            end
        end
    end
    assign result = result_ff;

    a_prst_off : assert property (@(posedge clk) disable iff (!rst_n)
        !prst_en |-> !prst_pulse) else $error("periodic reset while disabled");
endmodule

/* src/adm_coef.sv */
`timescale 1ns/1ps
// double-buffered coefficient store with synchronized swap
module adm_coef #(
    parameter int NC = 16
) (
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic         running,
    input  wire logic         adaptive,
    input  wire logic         frame_tick,
    input  wire logic         swap_req,
    input  wire logic         wr,
    input  wire logic         wr_buf_b,
    input  wire logic [3:0]   idx,
    input  wire logic [7:0]   wdata,
    output logic      [7:0]   rdata_a,
    output logic      [7:0]   rdata_b,
    output logic              in_use_b,
    output logic              swap_done
);
    logic [7:0] buf_a[NC];
    logic [7:0] buf_b[NC];
    logic       in_use_b_ff;
    logic       tgt_b;

    // running: always the idle buffer, else the addressed one
    assign tgt_b = running ? !in_use_b_ff : wr_buf_b;

    always_ff @(posedge clk) begin
        if (wr && (!running || adaptive)) begin
            if (tgt_b) begin
                buf_b[idx] <= wdata;
            end else begin
                buf_a[idx] <= wdata;
            end
        end
    end

    // exchange only at a sample boundary
    assign swap_done = running && adaptive && swap_req && frame_tick;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            in_use_b_ff <= 1'b0;
        end else if (swap_done) begin
            in_use_b_ff <= !in_use_b_ff;
        end
    end
    assign in_use_b = in_use_b_ff;
    assign rdata_a  = buf_a[idx];
    assign rdata_b  = buf_b[idx];

    a_swap_toggle : assert property (@(posedge clk) disable iff (!rst_n)
        swap_done |=> in_use_b_ff != $past(in_use_b_ff)) else $error("flag did not toggle");
    a_swap_sync : assert property (@(posedge clk) disable iff (!rst_n)
        swap_done |-> frame_tick && adaptive) else $error("swap off boundary");
endmodule

/* src/adm_top.sv */
// top of the record-path measurement and coefficient control block
// What this block does
// - nonzero enable field turns on measurement
// - mode bit 0 selects averaging filter
// - mode bit 1 selects first-order iir
// - length 1..20 sets iir bandwidth
// - periodic reset every 2^R modulator ticks, averaging mode only
// - reset-enable low means never reset
// - six-bit field selects fast-charge modes
// - unrouted inputs are left floating
// - anti-thump off at reset, write enables
// - running without adaptive locks coefficients
// - adaptive bit enables two coefficient buffers
// - swap request acts at next sample
// - swap request self-clears after exchange
// - in-use flag toggles, 0 A, 1 B
// - running writes go to idle buffer
//
// Design decisions made here: the address map and the strobed register port.
`timescale 1ns/1ps
module adm_top #(
    parameter int MOD_DIV = 4,
    parameter int FS_DIV  = 128
) (
    input  wire logic        REF_CLK,
    input  wire logic        RESETN,
    input  wire logic [7:0]  ADDR,
    input  wire logic [7:0]  WDATA,
    input  wire logic        WR,
    input  wire logic        RD,
    output logic      [7:0]  RDATA,
    input  wire logic [23:0] LEFT_SAMPLE,
    input  wire logic [23:0] RIGHT_SAMPLE,
    output logic      [5:0]  INPUT_HIZ,
    output logic      [5:0]  ANTI_THUMP_EN,
    output logic      [5:0]  FAST_CHARGE_SEL,
    output logic             ADC_RUNNING,
    output logic             DCM_LEFT_ON,
    output logic             DCM_RIGHT_ON
);
    logic [7:0]  page_ff;
    logic [7:0]  adc_pwr_ff;
    logic [7:0]  dcm_len_ff;
    logic [7:0]  dcm_ctrl_ff;
    logic [7:0]  dcm_latch_ff;
    logic [7:0]  anti_thump_ff;
    logic [7:0]  fast_charge_ff;
    logic [7:0]  route_ff;
    logic        adaptive_ff;
    logic        swap_req_ff;
    logic [7:0]  rdata_ff;
    logic [23:0] hold_l_ff;
    logic [23:0] hold_r_ff;
    logic [7:0]  mod_cnt_ff;
    logic [7:0]  fs_cnt_ff;
    logic        mod_tick;
    logic        fs_tick;
    logic        sw_reset;
    logic [23:0] res_l;
    logic [23:0] res_r;
    logic [7:0]  coef_a;
    logic [7:0]  coef_b;
    logic        in_use_b;
    logic        swap_done;
    logic        running;
    logic        coef_wr;
    logic        dcm_on_l;
    logic        dcm_on_r;
    logic [4:0]  dcm_d;
    logic [7:0]  nxt_rdata;

    function automatic logic hit(input logic [7:0] pg, input logic [7:0] rg);
        hit = (page_ff == pg) && (ADDR == rg);
    endfunction

    // page 0 register 1 bit 0 is the software reset strobe
    assign sw_reset = WR && hit(adm_pkg::PAGE_0, adm_pkg::REG_SW_RESET) && WDATA[0];
    assign running  = adc_pwr_ff[adm_pkg::ADC_PWR_L_BIT] || adc_pwr_ff[adm_pkg::ADC_PWR_R_BIT];
    assign dcm_on_l = dcm_ctrl_ff[adm_pkg::DCM_EN_HI];
    assign dcm_on_r = dcm_ctrl_ff[adm_pkg::DCM_EN_LO];
    // iir length sits in the control register, averaging length in its own
    assign dcm_d    = dcm_ctrl_ff[adm_pkg::DCM_MODE_BIT]
                      ? dcm_ctrl_ff[adm_pkg::DCM_LEN_HI:0]
                      : dcm_len_ff[adm_pkg::DCM_LEN_HI:0];

    // modulator and sample-rate enables from the one clock
    always_ff @(posedge REF_CLK or negedge RESETN) begin
        if (!RESETN) begin
            mod_cnt_ff <= '0;
            fs_cnt_ff  <= '0;
        end else begin
            mod_cnt_ff <= mod_tick ? 8'h00 : mod_cnt_ff + 8'h01;
            if (mod_tick) begin
                fs_cnt_ff <= fs_tick ? 8'h00 : fs_cnt_ff + 8'h01;
            end
        end
    end
    assign mod_tick = (mod_cnt_ff == 8'(MOD_DIV - 1));
    assign fs_tick  = mod_tick && (fs_cnt_ff == 8'(FS_DIV - 1));

    // page select, never cleared by software reset
    always_ff @(posedge REF_CLK or negedge RESETN) begin
        if (!RESETN) begin
            page_ff <= adm_pkg::RST_ZERO;
        end else if (WR && ADDR == adm_pkg::REG_PAGE_SEL) begin
            page_ff <= WDATA;
        end
    end

    // control registers; software reset returns them to defaults
    always_ff @(posedge REF_CLK or negedge RESETN) begin
        if (!RESETN) begin
            adc_pwr_ff     <= adm_pkg::RST_ZERO;
            dcm_len_ff     <= adm_pkg::RST_ZERO;
            dcm_ctrl_ff    <= adm_pkg::RST_ZERO;
            dcm_latch_ff   <= adm_pkg::RST_ZERO;
            anti_thump_ff  <= adm_pkg::RST_ZERO;
            fast_charge_ff <= adm_pkg::RST_ZERO;
            route_ff       <= adm_pkg::RST_ZERO;
            adaptive_ff    <= 1'b0;
        end else if (sw_reset) begin
            adc_pwr_ff     <= adm_pkg::RST_ZERO;
            dcm_len_ff     <= adm_pkg::RST_ZERO;
            dcm_ctrl_ff    <= adm_pkg::RST_ZERO;
            dcm_latch_ff   <= adm_pkg::RST_ZERO;
            anti_thump_ff  <= adm_pkg::RST_ZERO;
            fast_charge_ff <= adm_pkg::RST_ZERO;
            route_ff       <= adm_pkg::RST_ZERO;
            adaptive_ff    <= 1'b0;
        end else if (WR) begin
            if (hit(adm_pkg::PAGE_0, adm_pkg::REG_ADC_POWER)) adc_pwr_ff <= WDATA;
            if (hit(adm_pkg::PAGE_0, adm_pkg::REG_DCM_LEN)) dcm_len_ff <= WDATA;
            if (hit(adm_pkg::PAGE_0, adm_pkg::REG_DCM_CTRL)) dcm_ctrl_ff <= WDATA;
            if (hit(adm_pkg::PAGE_0, adm_pkg::REG_DCM_LATCH)) dcm_latch_ff <= WDATA;
            if (hit(adm_pkg::PAGE_1, adm_pkg::REG_ANTI_THUMP)) anti_thump_ff <= WDATA;
            if (hit(adm_pkg::PAGE_1, adm_pkg::REG_FAST_CHARGE)) fast_charge_ff <= WDATA;
            if (hit(adm_pkg::PAGE_1, adm_pkg::REG_INPUT_ROUTE)) route_ff <= WDATA;
            if (hit(adm_pkg::PAGE_8, adm_pkg::REG_COEF_CTRL)) begin
                adaptive_ff <= WDATA[adm_pkg::ADAPT_BIT];
            end
        end
    end

    // swap request: host sets, hardware clears after exchange
    always_ff @(posedge REF_CLK or negedge RESETN) begin
        if (!RESETN) begin
            swap_req_ff <= 1'b0;
        end else if (sw_reset || swap_done) begin
            swap_req_ff <= 1'b0;
        end else if (WR && hit(adm_pkg::PAGE_8, adm_pkg::REG_COEF_CTRL)
                     && WDATA[adm_pkg::SWAP_BIT]) begin
            swap_req_ff <= 1'b1;
        end
    end

    // left and right measurement filters share the setup
    adm_filter #(.DW(adm_pkg::DATA_W)) u_filt_l (
        .clk        (REF_CLK),
        .rst_n      (RESETN),
        .enable     (dcm_on_l),
        .mod_tick   (mod_tick),
        .iir_mode   (dcm_ctrl_ff[adm_pkg::DCM_MODE_BIT]),
        .len        (dcm_d),
        .prst_en    (dcm_latch_ff[adm_pkg::PRST_EN_BIT]),
        .prst_exp   (dcm_latch_ff[adm_pkg::DCM_LEN_HI:0]),
        .sample     (LEFT_SAMPLE),
        .result     (res_l),
        .prst_pulse ()
    );
    adm_filter #(.DW(adm_pkg::DATA_W)) u_filt_r (
        .clk        (REF_CLK),
        .rst_n      (RESETN),
        .enable     (dcm_on_r),
        .mod_tick   (mod_tick),
        .iir_mode   (dcm_ctrl_ff[adm_pkg::DCM_MODE_BIT]),
        .len        (dcm_d),
        .prst_en    (dcm_latch_ff[adm_pkg::PRST_EN_BIT]),
        .prst_exp   (dcm_latch_ff[adm_pkg::DCM_LEN_HI:0]),
        .sample     (RIGHT_SAMPLE),
        .result     (res_r),
        .prst_pulse ()
    );

    // read-back holding copy; frozen while the latch field is nonzero
    always_ff @(posedge REF_CLK or negedge RESETN) begin
        if (!RESETN) begin
            hold_l_ff <= '0;
            hold_r_ff <= '0;
        end else if (dcm_latch_ff[adm_pkg::LATCH_HI:adm_pkg::LATCH_LO] == 2'b00) begin
            hold_l_ff <= res_l;
            hold_r_ff <= res_r;
        end
    end

    // coefficient window on page 8; page select and control share its low end and must not land
    assign coef_wr = WR && (page_ff == adm_pkg::PAGE_8)
                     && (ADDR[7:4] == adm_pkg::REG_COEF_BASE[7:4])
                     && (ADDR[3:1] != 3'b000);

    adm_coef #(.NC(adm_pkg::N_COEF)) u_coef (
        .clk        (REF_CLK),
        .rst_n      (RESETN),
        .running    (running),
        .adaptive   (adaptive_ff),
        .frame_tick (fs_tick),
        .swap_req   (swap_req_ff),
        .wr         (coef_wr),
        .wr_buf_b   (ADDR[3]),
        .idx        ({1'b0, ADDR[2:0]}),
        .wdata      (WDATA),
        .rdata_a    (coef_a),
        .rdata_b    (coef_b),
        .in_use_b   (in_use_b),
        .swap_done  (swap_done)
    );

    // read mux; locked coefficients read as zero
    always_comb begin
        nxt_rdata = 8'h00;
        if (ADDR == adm_pkg::REG_PAGE_SEL) begin
            nxt_rdata = page_ff;
        end else if (page_ff == adm_pkg::PAGE_0) begin
            unique case (ADDR)
                adm_pkg::REG_ADC_POWER:           nxt_rdata = adc_pwr_ff;
                adm_pkg::REG_DCM_LEN:             nxt_rdata = dcm_len_ff;
                adm_pkg::REG_DCM_CTRL:            nxt_rdata = dcm_ctrl_ff;
                adm_pkg::REG_DCM_LATCH:           nxt_rdata = dcm_latch_ff;
                adm_pkg::REG_DCM_LEFT0:           nxt_rdata = hold_l_ff[23:16];
                adm_pkg::REG_DCM_LEFT0 + 8'h01:   nxt_rdata = hold_l_ff[15:8];
                adm_pkg::REG_DCM_LEFT0 + 8'h02:   nxt_rdata = hold_l_ff[7:0];
                adm_pkg::REG_DCM_RIGHT0:          nxt_rdata = hold_r_ff[23:16];
                adm_pkg::REG_DCM_RIGHT0 + 8'h01:  nxt_rdata = hold_r_ff[15:8];
                adm_pkg::REG_DCM_RIGHT0 + 8'h02:  nxt_rdata = hold_r_ff[7:0];
                default:                          nxt_rdata = 8'h00;
            endcase
        end else if (page_ff == adm_pkg::PAGE_1) begin
            unique case (ADDR)
                adm_pkg::REG_ANTI_THUMP:  nxt_rdata = anti_thump_ff;
                adm_pkg::REG_FAST_CHARGE: nxt_rdata = fast_charge_ff;
                adm_pkg::REG_INPUT_ROUTE: nxt_rdata = route_ff;
                default:                  nxt_rdata = 8'h00;
            endcase
        end else if (page_ff == adm_pkg::PAGE_8) begin
            if (ADDR == adm_pkg::REG_COEF_CTRL) begin
                nxt_rdata = {5'h00, adaptive_ff, in_use_b, swap_req_ff};
            end else if (ADDR[7:4] == adm_pkg::REG_COEF_BASE[7:4]
                         && (!running || adaptive_ff)) begin
                nxt_rdata = ADDR[3] ? coef_b : coef_a;
            end
        end
    end

    always_ff @(posedge REF_CLK or negedge RESETN) begin
        if (!RESETN) begin
            rdata_ff <= 8'h00;
        end else if (RD) begin
            rdata_ff <= nxt_rdata;
        end else begin
            rdata_ff <= 8'h00;
        end
    end

    assign RDATA           = rdata_ff;
    assign INPUT_HIZ       = ~route_ff[adm_pkg::N_INPUTS-1:0];
    assign ANTI_THUMP_EN   = anti_thump_ff[adm_pkg::AT_HI:adm_pkg::AT_LO];
    assign FAST_CHARGE_SEL = fast_charge_ff[adm_pkg::FC_HI:0];
    assign ADC_RUNNING     = running;
    assign DCM_LEFT_ON     = dcm_on_l;
    assign DCM_RIGHT_ON    = dcm_on_r;

    a_swap_clear : assert property (@(posedge REF_CLK) disable iff (!RESETN)
        swap_done |=> !swap_req_ff) else $error("swap request not cleared");
    a_swap_hold : assert property (@(posedge REF_CLK) disable iff (!RESETN)
        swap_req_ff && !fs_tick && !sw_reset |=> swap_req_ff) else $error("swap lost");
    a_at_reset : assert property (@(posedge REF_CLK) disable iff (!RESETN)
        sw_reset |=> ANTI_THUMP_EN == 6'h00) else $error("anti-thump not off");
    a_hiz_route : assert property (@(posedge REF_CLK) disable iff (!RESETN)
        (INPUT_HIZ & route_ff[5:0]) == 6'h00) else $error("routed pin floating");
    a_dcm_enable : assert property (@(posedge REF_CLK) disable iff (!RESETN)
        WR && hit(adm_pkg::PAGE_0, adm_pkg::REG_DCM_CTRL) && WDATA[7:6] != 2'b00
        |=> DCM_LEFT_ON || DCM_RIGHT_ON) else $error("measurement not enabled");
    a_fc_write : assert property (@(posedge REF_CLK) disable iff (!RESETN)
        WR && !sw_reset && hit(adm_pkg::PAGE_1, adm_pkg::REG_FAST_CHARGE)
        |=> FAST_CHARGE_SEL == $past(WDATA[5:0])) else $error("fast charge lost");
    a_lock_read : assert property (@(posedge REF_CLK) disable iff (!RESETN)
        RD && page_ff == adm_pkg::PAGE_8 && ADDR[7:4] == 4'h0 && ADDR[3] && running
        && !adaptive_ff |=> RDATA == 8'h00) else $error("locked read leaked");
    a_rd_idle : assert property (@(posedge REF_CLK) disable iff (!RESETN)
        !RD |=> RDATA == 8'h00) else $error("read data outside slot");
    a_latch_hold : assert property (@(posedge REF_CLK) disable iff (!RESETN)
        dcm_latch_ff[adm_pkg::LATCH_HI:adm_pkg::LATCH_LO] != 2'b00
        |=> $stable(hold_l_ff) && $stable(hold_r_ff)) else $error("latched result moved");
    a_sw_clear : assert property (@(posedge REF_CLK) disable iff (!RESETN)
        sw_reset |=> !ADC_RUNNING && !DCM_LEFT_ON && !DCM_RIGHT_ON
        && FAST_CHARGE_SEL == 6'h00) else $error("software reset left state");

    c_swap    : cover property (@(posedge REF_CLK) disable iff (!RESETN) swap_done);
    c_latch   : cover property (@(posedge REF_CLK) disable iff (!RESETN) dcm_latch_ff[7:6] != 2'b00);
    c_iir     : cover property (@(posedge REF_CLK) disable iff (!RESETN) dcm_on_l && dcm_ctrl_ff[5]);
    c_lockwr  : cover property (@(posedge REF_CLK) disable iff (!RESETN) coef_wr && running);
    c_redir   : cover property (@(posedge REF_CLK) disable iff (!RESETN)
        coef_wr && running && adaptive_ff);
endmodule

/* testbench/adm_host.sv */
`timescale 1ns/1ps
// host model: drives the register port one strobe at a time
module adm_host (
    input  wire logic       clk,
    output logic      [7:0] addr,
    output logic      [7:0] wdata,
    output logic            wr,
    output logic            rd
);
    // quiet bus from time zero
    initial begin
        addr  = 8'h00;
        wdata = 8'h00;
        wr    = 1'b0;
        rd    = 1'b0;
    end

    // one write cycle; strobe dropped at the edge that takes it
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk);
        wr    <= 1'b0;
    endtask

    // one read cycle; data are checked by the bench a cycle later
    task automatic rd_reg(input logic [7:0] a);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd   <= 1'b0;
    endtask

    // select the page first, since addresses only mean something inside one
    task automatic wr_pg(input logic [7:0] p, input logic [7:0] a, input logic [7:0] d);
        wr_reg(adm_pkg::REG_PAGE_SEL, p);
        wr_reg(a, d);
    endtask
endmodule

/* testbench/adm_top_test.sv */
`timescale 1ns/1ps
// self-checking bench of the measurement and coefficient control block
module adm_top_test;
    logic        ref_clk   = 1'b0;
    logic        rst_n     = 1'b0;
    logic        rd_d      = 1'b0;
    logic [23:0] left_s    = 24'h000000;
    logic [23:0] right_s   = 24'h000000;
    logic [31:0] rng       = 32'h000065EA;
    logic [7:0]  addr;
    logic [7:0]  wdata;
    logic [7:0]  rdata;
    logic [7:0]  v;
    logic        wr;
    logic        rd;
    logic [5:0]  hiz;
    logic [5:0]  thump;
    logic [5:0]  fchg;
    logic        running;
    logic        dcm_l;
    logic        dcm_r;
    logic [7:0]  exp_q[$];
    int          bad_count = 0;
    int          checks    = 0;

    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction

    always #5 ref_clk = ~ref_clk;

    // random converter samples keep the filters busy
    always @(posedge ref_clk) begin
        rng     <= xs(rng);
        left_s  <= rng[23:0];
        right_s <= ~rng[31:8];
    end

    adm_host i_host (.clk(ref_clk), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd));

    // short tick dividers: one sample period is 2*4 clocks
    adm_top #(.MOD_DIV(2), .FS_DIV(4)) i_dut (
        .REF_CLK(ref_clk), .RESETN(rst_n), .ADDR(addr), .WDATA(wdata), .WR(wr),
        .RD(rd), .RDATA(rdata), .LEFT_SAMPLE(left_s), .RIGHT_SAMPLE(right_s),
        .INPUT_HIZ(hiz), .ANTI_THUMP_EN(thump), .FAST_CHARGE_SEL(fchg),
        .ADC_RUNNING(running), .DCM_LEFT_ON(dcm_l), .DCM_RIGHT_ON(dcm_r)
    );

    task automatic cmp(input logic [7:0] got, input logic [7:0] e);
        checks++;
        if (got !== e) begin
            bad_count++;
            $display("unexpected at %0t: got %h want %h", $time, got, e);
        end
    endtask

    // note the expected read data, then issue the read
    task automatic rd_exp(input logic [7:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        i_host.rd_reg(a);
    endtask

    // read data stand only in the cycle after the strobe; look mid-cycle
    always @(posedge ref_clk) rd_d <= rd;
    always @(negedge ref_clk) begin
        if (rd_d) cmp(rdata, exp_q.pop_front());
    end

    task automatic results;
        $display("checks %0d bad_count %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // watchdog: the sequence needs well under 1000 clocks
    initial begin
        #50000;
        bad_count++;
        results();
    end

    initial begin
        repeat (20) @(posedge ref_clk);
        rst_n <= 1'b1;
        @(negedge ref_clk);
        cmp({2'b00, hiz}, 8'h3F);
        cmp({2'b00, thump}, 8'h00);
        // random analog set-up on page 1
        v = rng[7:0];
        i_host.wr_pg(adm_pkg::PAGE_1, adm_pkg::REG_ANTI_THUMP, v);
        i_host.wr_reg(adm_pkg::REG_FAST_CHARGE, ~v);
        i_host.wr_reg(adm_pkg::REG_INPUT_ROUTE, v);
        @(negedge ref_clk);
        cmp({2'b00, thump}, {2'b00, v[7:2]});
        cmp({2'b00, fchg}, {2'b00, ~v[5:0]});
        cmp({2'b00, hiz}, {2'b00, ~v[5:0]});
        // every enable code, both filter modes
        i_host.wr_reg(adm_pkg::REG_PAGE_SEL, adm_pkg::PAGE_0);
        // latch, read back (filters idle since reset), then clear the field at once
        i_host.wr_reg(adm_pkg::REG_DCM_LATCH, 8'hC0);
        rd_exp(adm_pkg::REG_DCM_LATCH, 8'hC0);
        rd_exp(adm_pkg::REG_DCM_LEFT0, 8'h00);
        rd_exp(adm_pkg::REG_DCM_RIGHT0 + 8'h02, 8'h00);
        i_host.wr_reg(adm_pkg::REG_DCM_LATCH, 8'h26);
        for (int k = 0; k < 4; k++) begin
            i_host.wr_reg(adm_pkg::REG_DCM_CTRL, {k[1:0], k[0], 5'h14});
            @(negedge ref_clk);
            cmp({6'h00, dcm_l, dcm_r}, {6'h00, k[1:0]});
        end
        // coefficients open while stopped, locked once running
        i_host.wr_pg(adm_pkg::PAGE_8, adm_pkg::REG_COEF_BASE, 8'h5A);
        rd_exp(adm_pkg::REG_COEF_BASE, 8'h5A);
        i_host.wr_pg(adm_pkg::PAGE_0, adm_pkg::REG_ADC_POWER, 8'h80);
        @(negedge ref_clk);
        cmp({7'h00, running}, 8'h01);
        i_host.wr_pg(adm_pkg::PAGE_8, adm_pkg::REG_COEF_BASE, 8'hA5);
        rd_exp(adm_pkg::REG_COEF_BASE, 8'h00);
        i_host.wr_reg(adm_pkg::REG_COEF_CTRL, 8'h04);
        rd_exp(adm_pkg::REG_COEF_CTRL, 8'h04);
        // two swaps: flag goes to B and back, request clears itself
        for (int k = 0; k < 2; k++) begin
            i_host.wr_reg(adm_pkg::REG_COEF_CTRL, 8'h05);
            repeat (12) @(posedge ref_clk);
            rd_exp(adm_pkg::REG_COEF_CTRL, k ? 8'h04 : 8'h06);
        end
        // buffer A in use again: an A address must land in idle buffer B
        i_host.wr_reg(8'h02, 8'h3C);
        rd_exp(8'h0A, 8'h3C);
        rd_exp(adm_pkg::REG_COEF_BASE, 8'h5A);
        // software reset clears page 1 set-up and the running state
        i_host.wr_pg(adm_pkg::PAGE_0, adm_pkg::REG_SW_RESET, 8'h01);
        repeat (2) @(negedge ref_clk);
        cmp({2'b00, thump}, 8'h00);
        cmp({1'b0, running, hiz}, 8'h3F);
        rd_exp(8'hF0, 8'h00);
        repeat (4) @(posedge ref_clk);
        results();
    end
endmodule
